// ==== hw/thsal_defs.svh ====
// Contract
// - local high sets status1 bit7, low bit6
// - remote high sets bit5, remote low bit4
// - diode open/short sets bit3; bits2-0 reserved
// - local/remote overtemp limit set status2 bits7/6
// - overtemp on-time percent over limit sets bit4
// - overtemp exceeded and pin asserted sets bit3
// - pin-state bit2; clears only if inactive
// - fan stall sets status3 bit7, alarm bit6
// - status3 bit0 shows device driving alert
// - out-of-limit measurement asserts alert unless masked
// - config1 bit3 selects latched or comparator mode
// - latched mode: unmasked set status drives alert
// - latched alert holds until cleared after recovery
// - release only when nothing else out of limit
// - comparator mode releases alert automatically
// - status bits sticky; clear by read or ARA
// - high is greater-or-equal, low is strictly below
// - mask blocks alert, status still sets
`ifndef THSAL_DEFS_SVH
`define THSAL_DEFS_SVH

// register offsets
`define THSAL_CFG1_ADDR     8'h01
`define THSAL_MASK1_ADDR    8'h08
`define THSAL_MASK2_ADDR    8'h09
`define THSAL_MASK3_ADDR    8'h0a
`define THSAL_LIM_BASE      8'h0b
`define THSAL_LIM_LAST      8'h10
`define THSAL_STAT1_ADDR    8'h4f
`define THSAL_STAT2_ADDR    8'h50
`define THSAL_STAT3_ADDR    8'h51

// limit indices relative to the limit base
`define THSAL_LIM_LHIGH     3'h0
`define THSAL_LIM_LLOW      3'h1
`define THSAL_LIM_LOT       3'h2
`define THSAL_LIM_RHIGH     3'h3
`define THSAL_LIM_RLOW      3'h4
`define THSAL_LIM_ROT       3'h5
`define THSAL_LIM_NUM       6

// reset values
`define THSAL_CFG1_RST      8'h01
`define THSAL_MASK_RST      8'h00
`define THSAL_HIGH_RST      8'h8b
`define THSAL_LOW_RST       8'h54
`define THSAL_OT_RST        8'h95

// field positions
`define THSAL_CFG1_MODE_BIT 3
`define THSAL_LH_BIT        7
`define THSAL_LL_BIT        6
`define THSAL_RH_BIT        5
`define THSAL_RL_BIT        4
`define THSAL_RD_BIT        3
`define THSAL_LT_BIT        7
`define THSAL_RT_BIT        6
`define THSAL_TPCT_BIT      4
`define THSAL_TA_BIT        3
`define THSAL_TS_BIT        2
`define THSAL_FS_BIT        7
`define THSAL_FA_BIT        6
`define THSAL_AL_BIT        0

// implemented bits of each status and mask register
`define THSAL_STAT1_IMPL    8'hf8
`define THSAL_STAT2_IMPL    8'hdc
`define THSAL_STAT3_IMPL    8'hc0

`endif

// ==== hw/thsal_pkg.sv ====
package thsal_pkg;
	// alert output behaviour, picked by config1
	typedef enum logic {
		THSAL_MODE_LATCH,
		THSAL_MODE_COMP
	} thsal_mode_t;

	// one status, mask or limit byte
	typedef logic [7:0] thsal_byte_t;
endpackage : thsal_pkg

// ==== hw/thsal_limit_cmp.sv ====
`timescale 1ns/1ns
`default_nettype none
// one channel: high, low and overtemp comparisons
module thsal_limit_cmp #(
	parameter int W = 8
) (
	// reading and its limits
	input  wire logic [W-1:0] value_i,
	input  wire logic [W-1:0] high_i,
	input  wire logic [W-1:0] low_i,
	input  wire logic [W-1:0] ot_i,
	// comparison results
	output logic              high_o,
	output logic              low_o,
	output logic              ot_o
);
	// high and overtemp trip at equality, low only strictly below
	assign high_o = (value_i >= high_i);
	assign low_o  = (value_i <  low_i);
	assign ot_o   = (value_i >= ot_i);
endmodule : thsal_limit_cmp
`default_nettype wire

// ==== hw/thsal_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "thsal_defs.svh"
module thsal_top
	import thsal_pkg::*;
(
	// clock and reset
	input  wire logic       ref_clk_i,
	input  wire logic       nrst_i,
	// register access port
	input  wire logic       reg_rd_i,
	input  wire logic       reg_wr_i,
	input  wire logic [7:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	output logic [7:0]      reg_rdata_o,
	output logic            reg_rvalid_o,
	// alert-response cycle completed
	input  wire logic       ara_done_i,
	// measurement engine results
	input  wire logic [7:0] local_temp_i,
	input  wire logic       local_done_i,
	input  wire logic [7:0] remote_temp_i,
	input  wire logic       remote_done_i,
	input  wire logic       remote_diode_fault_i,
	// overtemp pin and fan monitor levels
	input  wire logic       overtemp_pin_active_i,
	input  wire logic       overtemp_pct_over_i,
	input  wire logic       fan_stall_i,
	input  wire logic       fan_alarm_i,
	// open-drain alert line
	input  wire logic       alert_line_n_i,
	output logic            alert_n_o,
	output logic            alert_oe_o
);

	// limit registers, indexed from the limit base
	thsal_byte_t lim_q [`THSAL_LIM_NUM];
	thsal_byte_t cfg1_q;                      // config1, mode bit inside
	thsal_byte_t mask_q [3];                  // mask1..3
	thsal_byte_t stat_q [3];                  // status1..3 sticky bits
	thsal_byte_t cond   [3];                  // live out-of-limit conditions
	thsal_byte_t clr    [3];                  // per-bit clear this cycle
	thsal_byte_t rdata_d;                     // read mux
	logic        alert_q;                     // device pulls the line low
	logic        alert_d;
	logic        lh_q, ll_q, lt_q;            // local channel out-of-limit
	logic        rh_q, rl_q, rt_q, rd_q;      // remote channel out-of-limit
	logic        l_hi, l_lo, l_ot;            // local comparator outputs
	logic        r_hi, r_lo, r_ot;            // remote comparator outputs
	thsal_mode_t mode;

	// map an address to a status index, 3 when not a status register
	function automatic logic [1:0] stat_idx(input logic [7:0] a);
		case (a)
			`THSAL_STAT1_ADDR: return 2'd0;
			`THSAL_STAT2_ADDR: return 2'd1;
			`THSAL_STAT3_ADDR: return 2'd2;
			default:           return 2'd3;
		endcase
	endfunction : stat_idx

	// map an address to a mask index, 3 when not a mask register
	function automatic logic [1:0] mask_idx(input logic [7:0] a);
		case (a)
			`THSAL_MASK1_ADDR: return 2'd0;
			`THSAL_MASK2_ADDR: return 2'd1;
			`THSAL_MASK3_ADDR: return 2'd2;
			default:           return 2'd3;
		endcase
	endfunction : mask_idx

	// implemented-bit pattern of status/mask register i
	function automatic thsal_byte_t impl_bits(input int i);
		case (i)
			0:       return `THSAL_STAT1_IMPL;
			1:       return `THSAL_STAT2_IMPL;
			default: return `THSAL_STAT3_IMPL;
		endcase
	endfunction : impl_bits

	// reset value of limit register i
	function automatic thsal_byte_t lim_rst(input int i);
		case (i)
			int'(`THSAL_LIM_LOT), int'(`THSAL_LIM_ROT):   return `THSAL_OT_RST;
			int'(`THSAL_LIM_LLOW), int'(`THSAL_LIM_RLOW): return `THSAL_LOW_RST;
			default:                                      return `THSAL_HIGH_RST;
		endcase
	endfunction : lim_rst

	assign mode = cfg1_q[`THSAL_CFG1_MODE_BIT] ? THSAL_MODE_COMP : THSAL_MODE_LATCH;

	// the same comparator module, one instance per channel
	thsal_limit_cmp #(.W(8)) u_cmp_local (
		.value_i (local_temp_i),
		.high_i  (lim_q[`THSAL_LIM_LHIGH]),
		.low_i   (lim_q[`THSAL_LIM_LLOW]),
		.ot_i    (lim_q[`THSAL_LIM_LOT]),
		.high_o  (l_hi),
		.low_o   (l_lo),
		.ot_o    (l_ot)
	);
	thsal_limit_cmp #(.W(8)) u_cmp_remote (
		.value_i (remote_temp_i),
		.high_i  (lim_q[`THSAL_LIM_RHIGH]),
		.low_i   (lim_q[`THSAL_LIM_RLOW]),
		.ot_i    (lim_q[`THSAL_LIM_ROT]),
		.high_o  (r_hi),
		.low_o   (r_lo),
		.ot_o    (r_ot)
	);

	// limit registers, written through the register port
	generate
		for (genvar g = 0; g < `THSAL_LIM_NUM; g++) begin : g_lim
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					lim_q[g] <= lim_rst(g);
				end else if (reg_wr_i && reg_addr_i == `THSAL_LIM_BASE + 8'(g)) begin
					lim_q[g] <= reg_wdata_i;
				end
			end
		end
	endgenerate

	// config1 write
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			cfg1_q <= `THSAL_CFG1_RST;
		end else if (reg_wr_i && reg_addr_i == `THSAL_CFG1_ADDR) begin
			cfg1_q <= reg_wdata_i;
		end
	end

	// mask writes; reserved positions cannot be set
	generate
		for (genvar g = 0; g < 3; g++) begin : g_mask
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					mask_q[g] <= `THSAL_MASK_RST;
				end else if (reg_wr_i && mask_idx(reg_addr_i) == 2'(g)) begin
					mask_q[g] <= reg_wdata_i & impl_bits(g);
				end
			end
		end
	endgenerate

	// channel state refreshed only when a conversion completes
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			lh_q <= 1'b0;
			ll_q <= 1'b0;
			lt_q <= 1'b0;
		end else if (local_done_i) begin
			lh_q <= l_hi;
			ll_q <= l_lo;
			lt_q <= l_ot;
		end
	end

	// remote channel; a diode fault invalidates the reading
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rh_q <= 1'b0;
			rl_q <= 1'b0;
			rt_q <= 1'b0;
			rd_q <= 1'b0;
		end else if (remote_done_i) begin
			rh_q <= r_hi && !remote_diode_fault_i;
			rl_q <= r_lo && !remote_diode_fault_i;
			rt_q <= r_ot && !remote_diode_fault_i;
			rd_q <= remote_diode_fault_i;
		end
	end

	// live condition vectors; reserved positions stay zero
	always_comb begin
		cond[0] = '0;
		cond[1] = '0;
		cond[2] = '0;
		cond[0][`THSAL_LH_BIT]   = lh_q;
		cond[0][`THSAL_LL_BIT]   = ll_q;
		cond[0][`THSAL_RH_BIT]   = rh_q;
		cond[0][`THSAL_RL_BIT]   = rl_q;
		cond[0][`THSAL_RD_BIT]   = rd_q;
		cond[1][`THSAL_LT_BIT]   = lt_q;
		cond[1][`THSAL_RT_BIT]   = rt_q;
		cond[1][`THSAL_TPCT_BIT] = overtemp_pct_over_i;
		cond[1][`THSAL_TA_BIT]   = (lt_q || rt_q) && overtemp_pin_active_i;
		cond[1][`THSAL_TS_BIT]   = overtemp_pin_active_i;
		cond[2][`THSAL_FS_BIT]   = fan_stall_i;
		cond[2][`THSAL_FA_BIT]   = fan_alarm_i;
	end

	// sticky status: a read clears only bits whose condition has gone,
	// an alert-response cycle clears all; a live condition always wins
	generate
		for (genvar g = 0; g < 3; g++) begin : g_stat
			always_comb begin
				clr[g] = '0;
				if (ara_done_i) begin
					clr[g] = '1;
				end else if (reg_rd_i && stat_idx(reg_addr_i) == 2'(g)) begin
					clr[g] = ~cond[g];
				end
			end
			always_ff @(posedge ref_clk_i or negedge nrst_i) begin
				if (!nrst_i) begin
					stat_q[g] <= '0;
				end else begin
					stat_q[g] <= ((stat_q[g] & ~clr[g]) | cond[g]) & impl_bits(g);
				end
			end
		end
	endgenerate

	// alert decision; the pin-state bit is ignored in comparator mode
	always_comb begin
		thsal_byte_t m2;
		m2 = ~mask_q[1];
		if (mode == THSAL_MODE_COMP) begin
			m2[`THSAL_TS_BIT] = 1'b0;
			alert_d = |(cond[0] & ~mask_q[0]) | |(cond[1] & m2)
				| |(cond[2] & ~mask_q[2]);
		end else begin
			alert_d = |(stat_q[0] & ~mask_q[0]) | |(stat_q[1] & m2)
				| |(stat_q[2] & ~mask_q[2]);
		end
	end

	// alert driver state
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			alert_q <= 1'b0;
		end else begin
			alert_q <= alert_d;
		end
	end

	// open-drain: only ever pull low, else release
	assign alert_n_o  = 1'b0;
	assign alert_oe_o = alert_q;

	// read mux
	always_comb begin
		rdata_d = '0;
		unique case (stat_idx(reg_addr_i))
			2'd0: rdata_d = stat_q[0];
			2'd1: rdata_d = stat_q[1];
			2'd2: begin
				rdata_d = stat_q[2];
				rdata_d[`THSAL_AL_BIT] = alert_q;
			end
			2'd3: begin
				if (reg_addr_i == `THSAL_CFG1_ADDR) begin
					rdata_d = cfg1_q;
				end else if (mask_idx(reg_addr_i) != 2'd3) begin
					rdata_d = mask_q[mask_idx(reg_addr_i)];
				end else if (reg_addr_i >= `THSAL_LIM_BASE && reg_addr_i <= `THSAL_LIM_LAST) begin
					rdata_d = lim_q[3'(reg_addr_i - `THSAL_LIM_BASE)];
				end
			end
		endcase
	end

	// read data held until the next read; pre-clear value returned
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			reg_rdata_o  <= '0;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= rdata_d;
			end
		end
	end

	// checks
	sequence s_local_high;
		local_done_i && l_hi;
	endsequence
	property p_local_high;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		s_local_high |=> ##1 stat_q[0][`THSAL_LH_BIT];
	endproperty
	a_local_high: assert property (p_local_high) else $error("local high not flagged");
	property p_low_strict;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		remote_done_i && !remote_diode_fault_i |=> rl_q == ($past(remote_temp_i) < $past(lim_q[`THSAL_LIM_RLOW]));
	endproperty
	a_low_strict: assert property (p_low_strict) else $error("low compare wrong");
	property p_reserved_zero;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		reg_rvalid_o && $past(reg_addr_i) == `THSAL_STAT1_ADDR |-> reg_rdata_o[2:0] == 3'h0;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");
	property p_ts_keep;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		overtemp_pin_active_i && reg_rd_i && reg_addr_i == `THSAL_STAT2_ADDR && !ara_done_i
		|=> stat_q[1][`THSAL_TS_BIT];
	endproperty
	a_ts_keep: assert property (p_ts_keep) else $error("pin state cleared while active");
	property p_alert_bit;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		reg_rd_i && reg_addr_i == `THSAL_STAT3_ADDR |=> reg_rdata_o[`THSAL_AL_BIT] == $past(alert_oe_o);
	endproperty
	a_alert_bit: assert property (p_alert_bit) else $error("alert status bit wrong");
	property p_latch_alert;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		mode == THSAL_MODE_LATCH && |(stat_q[0] & ~mask_q[0]) |=> alert_oe_o && !alert_n_o;
	endproperty
	a_latch_alert: assert property (p_latch_alert) else $error("latched alert missing");
	sequence s_comp_quiet;
		mode == THSAL_MODE_COMP && !alert_d [*2];
	endsequence
	property p_comp_release;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		s_comp_quiet |-> !alert_oe_o;
	endproperty
	a_comp_release: assert property (p_comp_release) else $error("comparator alert held");
	property p_masked_sets;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		fan_stall_i && mask_q[2][`THSAL_FS_BIT] |=> stat_q[2][`THSAL_FS_BIT];
	endproperty
	a_masked_sets: assert property (p_masked_sets) else $error("masked status not set");
	property p_sticky;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		stat_q[2][`THSAL_FA_BIT] && !ara_done_i && !(reg_rd_i && reg_addr_i == `THSAL_STAT3_ADDR)
		|=> stat_q[2][`THSAL_FA_BIT];
	endproperty
	a_sticky: assert property (p_sticky) else $error("status bit not sticky");
	property p_open_drain;
		@(posedge ref_clk_i) disable iff (!nrst_i)
		alert_oe_o |-> !alert_line_n_i;
	endproperty
	a_open_drain: assert property (p_open_drain) else $error("alert line high while pulled");

endmodule : thsal_top
`default_nettype wire

// ==== dv/thsal_host_model.sv ====
`timescale 1ns/1ns
`default_nettype none
// host side of the block: register cycles, alert-response, alert service
module thsal_host_model
	import thsal_pkg::*;
(
	// clock
	input  wire logic       ref_clk_i,
	// read answer from the block
	input  wire logic [7:0] reg_rdata_i,
	input  wire logic       reg_rvalid_i,
	// requests toward the block
	output logic            reg_rd_o,
	output logic            reg_wr_o,
	output logic [7:0]      reg_addr_o,
	output logic [7:0]      reg_wdata_o,
	output logic            ara_done_o
);
	// idle bus at time zero
	initial begin
		reg_rd_o = 1'b0;
		reg_wr_o = 1'b0;
		reg_addr_o = 8'h00;
		reg_wdata_o = 8'h00;
		ara_done_o = 1'b0;
	end

	// single write; address and data scrambled once the strobe is gone
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge ref_clk_i) #1;
		reg_addr_o = a;
		reg_wdata_o = d;
		reg_wr_o = 1'b1;
		@(posedge ref_clk_i) #1;
		reg_wr_o = 1'b0;
		reg_addr_o = ~a;
		reg_wdata_o = ~d;
	endtask : wr

	// single read, answer awaited for a few cycles only
	task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic ok);
		int i;
		@(posedge ref_clk_i) #1;
		reg_addr_o = a;
		reg_rd_o = 1'b1;
		@(posedge ref_clk_i) #1;
		reg_rd_o = 1'b0;
		reg_addr_o = ~a;
		ok = 1'b0;
		d = 8'h00;
		for (i = 0; i < 4 && !ok; i++) begin
			if (reg_rvalid_i === 1'b1) begin
				ok = 1'b1;
				d = reg_rdata_i;
			end else begin
				@(posedge ref_clk_i) #1;
			end
		end
	endtask : rd

	// alert-response cycle finished, one pulse
	task automatic ara();
		@(posedge ref_clk_i) #1;
		ara_done_o = 1'b1;
		@(posedge ref_clk_i) #1;
		ara_done_o = 1'b0;
	endtask : ara

	// alert handler: read all status first to find the source
	task automatic svc(output logic [7:0] s1, s2, s3, output logic ok);
		logic o1, o2, o3;
		rd(8'h4f, s1, o1);
		rd(8'h50, s2, o2);
		rd(8'h51, s3, o3);
		ok = o1 & o2 & o3;
	endtask : svc
endmodule : thsal_host_model
`default_nettype wire

// ==== dv/tb_thsal_top.sv ====
`timescale 1ns/1ns
`default_nettype none
`include "thsal_defs.svh"
// self-checking bench for the status and alert block
module tb_thsal_top
	import thsal_pkg::*;
;
	logic       ref_clk_i = 1'b0;           // 100 MHz
	logic       nrst_i;                     // async, active low
	logic       reg_rd, reg_wr, ara_done;   // host strobes
	logic [7:0] reg_addr, reg_wdata, rdata; // host bus
	logic       rvalid, alert_n, alert_oe;  // block answers
	logic [7:0] local_temp, remote_temp;    // readings
	logic       local_done, remote_done, fault, pin, pct, stall, alarm;
	wire        alert_line_n;               // wired line, pull-up
	int         mismatches, total_checks, i;
	logic [31:0] seed;
	logic [7:0] l, r, e1, e2, s1, s2, s3;
	logic       f, ok;
	logic [7:0] ra[14] = '{8'h01, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0c, 8'h0d,
		8'h0e, 8'h0f, 8'h10, 8'h4f, 8'h50, 8'h51, 8'h02};
	logic [7:0] rv[14] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h8b, 8'h54, 8'h95,
		8'h8b, 8'h54, 8'h95, 8'h00, 8'h00, 8'h00, 8'h00};
	logic [7:0] crn[6] = '{8'h8b, 8'h8a, 8'h54, 8'h53, 8'h95, 8'h94};

	// only the block ever pulls the line; otherwise the pull-up wins
	assign alert_line_n = alert_oe ? 1'b0 : 1'b1;

	always #5 ref_clk_i = ~ref_clk_i;

	thsal_top i_thsal_top (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_rd_i(reg_rd),
		.reg_wr_i(reg_wr), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
		.reg_rdata_o(rdata), .reg_rvalid_o(rvalid), .ara_done_i(ara_done),
		.local_temp_i(local_temp), .local_done_i(local_done), .remote_temp_i(remote_temp),
		.remote_done_i(remote_done), .remote_diode_fault_i(fault),
		.overtemp_pin_active_i(pin), .overtemp_pct_over_i(pct), .fan_stall_i(stall),
		.fan_alarm_i(alarm), .alert_line_n_i(alert_line_n), .alert_n_o(alert_n),
		.alert_oe_o(alert_oe));

	thsal_host_model i_thsal_host_model (.ref_clk_i(ref_clk_i), .reg_rdata_i(rdata),
		.reg_rvalid_i(rvalid), .reg_rd_o(reg_rd), .reg_wr_o(reg_wr),
		.reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata), .ara_done_o(ara_done));

	// expected status bytes from readings and reset limits
	function automatic logic [7:0] e_s1(input logic [7:0] lt, rt, input logic ft);
		return {lt >= `THSAL_HIGH_RST, lt < `THSAL_LOW_RST, !ft && rt >= `THSAL_HIGH_RST,
			!ft && rt < `THSAL_LOW_RST, ft, 3'h0};
	endfunction : e_s1

	function automatic logic [7:0] e_s2(input logic [7:0] lt, rt, input logic ft);
		return {lt >= `THSAL_OT_RST, !ft && rt >= `THSAL_OT_RST, 6'h00};
	endfunction : e_s2

	task automatic chk8(input logic [7:0] id, input logic [7:0] e, input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error reg %h exp %h got %h", id, e, g);
		end
	endtask : chk8

	task automatic chk1(input string nm, input logic e, input logic g);
		total_checks++;
		if (g !== e) begin
			mismatches++;
			$display("Error %s exp %b got %b", nm, e, g);
		end
	endtask : chk1

	task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
		i_thsal_host_model.rd(a, s1, ok);
		chk1("rvalid", 1'b1, ok);
		chk8(a, e, s1);
	endtask : rdchk

	// wt: wait up to 4 cycles for e; else check e after 4 cycles
	task automatic oe(input logic e, input logic wt);
		int k;
		for (k = 0; k < 4 && (!wt || alert_oe !== e); k++) @(posedge ref_clk_i) #1;
		chk1("alert_oe", e, alert_oe);
	endtask : oe

	// one conversion of both channels; readings scrambled after done
	task automatic meas(input logic [7:0] lt, rt, input logic ft);
		@(posedge ref_clk_i) #1;
		{local_temp, remote_temp, fault} = {lt, rt, ft};
		{local_done, remote_done} = 2'b11;
		@(posedge ref_clk_i) #1;
		{local_done, remote_done} = 2'b00;
		{local_temp, remote_temp} = ~{lt, rt};
		repeat (2) @(posedge ref_clk_i);
		#1;
	endtask : meas

	task automatic end_sim();
		if (mismatches == 0 && total_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : end_sim

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		mismatches++;
		end_sim();
	end

	initial begin
		seed = 32'h45f49cb9;
		{mismatches, total_checks} = 0;
		{local_temp, remote_temp} = 16'h6060;
		{local_done, remote_done, fault, pin, pct, stall, alarm} = 7'h00;
		nrst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		nrst_i = 1'b1;
		// reset contents, unmapped address last
		for (i = 0; i < 14; i++) rdchk(ra[i], rv[i]);
		// limit corners first, then random readings; in latched mode
		for (i = 0; i < 24; i++) begin
			l = (i < 6) ? crn[i] : 8'($random(seed));
			r = (i < 6) ? crn[5 - i] : 8'($random(seed));
			f = (i % 7 == 3);
			meas(l, r, f);
			e1 = e_s1(l, r, f);
			e2 = e_s2(l, r, f);
			oe(|{e1, e2}, 1'b1);
			i_thsal_host_model.svc(s1, s2, s3, ok);
			chk1("rvalid", 1'b1, ok);
			chk8(8'h4f, e1, s1);
			chk8(8'h50, e2, s2);
			chk8(8'h51, {7'h00, |{e1, e2}}, s3);
			meas(8'h60, 8'h60, 1'b0);
			rdchk(8'h4f, e1);
			oe(|e2, 1'b0);
			rdchk(8'h50, e2);
			oe(1'b0, 1'b1);
			rdchk(8'h4f, 8'h00);
		end
		// fan sources, two at once, latched release
		stall = 1'b1;
		oe(1'b1, 1'b1);
		chk1("alert_n", 1'b0, alert_n);
		rdchk(8'h51, 8'h81);
		{stall, alarm} = 2'b01;
		rdchk(8'h51, 8'hc1);
		oe(1'b1, 1'b0);
		alarm = 1'b0;
		oe(1'b1, 1'b0);
		rdchk(8'h51, 8'h41);
		oe(1'b0, 1'b1);
		rdchk(8'h51, 8'h00);
		// mask: status sets, alert silent, reserved bits dropped
		i_thsal_host_model.wr(8'h0a, 8'hff);
		rdchk(8'h0a, 8'hc0);
		stall = 1'b1;
		oe(1'b0, 1'b0);
		stall = 1'b0;
		rdchk(8'h51, 8'h80);
		i_thsal_host_model.wr(8'h0a, 8'h00);
		// pin state clears only when the pin is idle
		pin = 1'b1;
		oe(1'b1, 1'b1);
		rdchk(8'h50, 8'h04);
		rdchk(8'h50, 8'h04);
		pin = 1'b0;
		rdchk(8'h50, 8'h04);
		rdchk(8'h50, 8'h00);
		pct = 1'b1;
		oe(1'b1, 1'b1);
		pct = 1'b0;
		rdchk(8'h50, 8'h10);
		// overtemp with the pin asserted
		pin = 1'b1;
		meas(8'h95, 8'h60, 1'b0);
		pin = 1'b0;
		meas(8'h60, 8'h60, 1'b0);
		rdchk(8'h50, 8'h8c);
		rdchk(8'h4f, 8'h80);
		rdchk(8'h50, 8'h00);
		// alert-response clears latched state
		alarm = 1'b1;
		oe(1'b1, 1'b1);
		alarm = 1'b0;
		i_thsal_host_model.ara();
		oe(1'b0, 1'b1);
		rdchk(8'h51, 8'h00);
		// programmed limit trips at equality; mask1 keeps the alert quiet
		i_thsal_host_model.wr(8'h0b, 8'h70);
		i_thsal_host_model.wr(8'h08, 8'hff);
		rdchk(8'h0b, 8'h70);
		rdchk(8'h08, 8'hf8);
		meas(8'h70, 8'h60, 1'b0);
		oe(1'b0, 1'b0);
		meas(8'h6f, 8'h60, 1'b0);
		rdchk(8'h4f, 8'h80);
		rdchk(8'h4f, 8'h00);
		i_thsal_host_model.wr(8'h08, 8'h00);
		// comparator mode: self release, pin state ignored
		i_thsal_host_model.wr(8'h01, 8'h09);
		rdchk(8'h01, 8'h09);
		alarm = 1'b1;
		oe(1'b1, 1'b1);
		alarm = 1'b0;
		oe(1'b0, 1'b1);
		pin = 1'b1;
		oe(1'b0, 1'b0);
		pin = 1'b0;
		rdchk(8'h51, 8'h40);
		// mid-run reset: written registers and sticky bits back to defaults
		nrst_i = 1'b0;
		repeat (4) @(posedge ref_clk_i);
		#1;
		nrst_i = 1'b1;
		rdchk(8'h01, 8'h01);
		rdchk(8'h0b, 8'h8b);
		rdchk(8'h50, 8'h00);
		oe(1'b0, 1'b0);
		end_sim();
	end
endmodule : tb_thsal_top
`default_nettype wire
